// >>> lacc_chk_sva.sv
// checker for the line address and byte-count control block
// assumes it is bound into lacc_top and sees only that module's ports
`timescale 1ns/1ps
module lacc_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        address_to_bus,
  input wire logic        data_strobe,
  input wire logic        end_cycle,
  input wire logic [3:0]  xmit_scan,
  input wire logic [17:0] bus_addr,
  input wire logic        bus_addr_oe,
  input wire logic        tx_hold_write,
  input wire logic [3:0]  tx_line,
  input wire logic        transfer_complete_pulse,
  input wire logic        address_memory_write,
  input wire logic        count_memory_write
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // register port answers once, only inside an access
  a_ready_single: assert property (pready |-> psel && penable ##1 !pready)
    else $error("pready outside access or held too long");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  // master phase drives the address out
  a_oe_on_master: assert property ($rose(address_to_bus) |=> bus_addr_oe)
    else $error("address enable missed");
  a_addr_idle_zero: assert property (!bus_addr_oe |-> bus_addr == 18'h00000)
    else $error("address driven while not master");
  a_hold_pulse: assert property ($rose(data_strobe) && address_to_bus |=> tx_hold_write ##1 !tx_hold_write)
    else $error("holding register write not one cycle");
  a_hold_line: assert property (tx_hold_write |-> tx_line == xmit_scan)
    else $error("holding register write to wrong line");
  a_addr_wr_width: assert property ($rose(address_memory_write) |-> address_memory_write[*6] ##1 !address_memory_write)
    else $error("address memory strobe width wrong");
  a_cnt_wr_width: assert property ($rose(count_memory_write) |-> count_memory_write[*6] ##1 !count_memory_write)
    else $error("count memory strobe width wrong");
  a_done_width: assert property ($rose(transfer_complete_pulse) |-> transfer_complete_pulse[*3] ##1 !transfer_complete_pulse)
    else $error("completion pulse width wrong");
  a_done_after_wr: assert property ($rose(transfer_complete_pulse) |-> $fell(address_memory_write))
    else $error("completion pulse not at end of write back");
  // write back must wait for the counter to settle
  a_inc_delay: assert property ($rose(end_cycle) |-> !address_memory_write[*8] ##[14:20] $rose(address_memory_write))
    else $error("write back delay wrong");

  cover property ($rose(transfer_complete_pulse));
  cover property ($rose(count_memory_write));
  cover property (pslverr);
endmodule

bind lacc_top lacc_chk i_chk (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
  .address_to_bus, .data_strobe, .end_cycle, .xmit_scan, .bus_addr, .bus_addr_oe,
  .tx_hold_write, .tx_line, .transfer_complete_pulse, .address_memory_write,
  .count_memory_write);

// >>> lacc_mem_model.sv
// system memory model answering the block's master reads
// assumes word data derived from the byte address; no wait states
`timescale 1ns/1ps
module lacc_mem_model (
  input  wire logic        pclk,
  input  wire logic [17:0] bus_addr,
  input  wire logic        bus_addr_oe,
  output logic      [15:0] bus_rd_data
);
  logic [15:0] last;

  // remember what stood on the bus
  always_ff @(posedge pclk) begin
    last <= bus_rd_data;
  end
  // high byte differs from low byte
  // released bus toggles so a stale value is never mistaken for data
  assign bus_rd_data = bus_addr_oe ? {~bus_addr[7:0], bus_addr[7:0]} : ~last;
endmodule

// >>> lacc_pkg.sv
// constants for the per-line address and byte-count control block
// assumes a 100 MHz pclk and a 32-bit apb register port
package lacc_pkg;
  // apb byte offsets
  localparam logic [11:0] OFF_SCR    = 12'h000;
  localparam logic [11:0] OFF_CAR    = 12'h004;
  localparam logic [11:0] OFF_BC     = 12'h008;
  localparam logic [11:0] OFF_STATUS = 12'h00c;

  // system control register fields and reset value
  localparam int          SCR_LINE_LSB = 0;   // line select, 4 bits
  localparam int          SCR_EXT_LSB  = 4;   // address bits 17:16
  localparam int          SCR_AE_BIT   = 6;   // auto-echo enable
  localparam logic [6:0]  SCR_RESET    = 7'h00;

  // status register fields
  localparam int          ST_ADDR_FLAG  = 0;
  localparam int          ST_COUNT_FLAG = 1;
  localparam int          ST_LOAD_BUSY  = 2;
  localparam int          ST_INC_BUSY   = 3;
  localparam int          ST_OVERFLOW   = 4;
  localparam int          ST_UPPER_LSB  = 6;  // stored address bits 17:16

  // widths
  localparam int          ADDR_W  = 18;
  localparam int          COUNT_W = 16;
  localparam int          LINES   = 16;

  // timing: figures in ns, counts in pclk cycles
  localparam int          CLK_PERIOD_NS    = 10;
  localparam int          LOAD_DELAY_NS    = 90;
  localparam int          WRITE_WIDTH_NS   = 60;
  localparam int          DONE_PULSE_NS    = 30;
  localparam int          INC_DELAY_NS     = 220;
  localparam logic [4:0]  LOAD_DELAY_CYC   =
    5'((LOAD_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [4:0]  WRITE_WIDTH_CYC  =
    5'((WRITE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [4:0]  DONE_PULSE_CYC   =
    5'((DONE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [4:0]  INC_DELAY_CYC    =
    5'((INC_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // one-shot chain states, gray along idle-delay-write-pulse
  typedef enum logic [1:0] {
    SEQ_IDLE  = 2'b00,
    SEQ_DELAY = 2'b01,
    SEQ_WRITE = 2'b11,
    SEQ_PULSE = 2'b10
  } lacc_seq_t;
endpackage

// >>> lacc_top.sv
// per-line current-address and byte-count control for a 16-line transmit dma path
// assumes apb master on pclk; sequencer, scanner and line cards are logic on pclk
// Behaviour
// - address load command parallel-loads address counter
// - load command end sets address write flag
// - address memory write 90 ns later, 60 ns
// - 30 ns pulse after write clears flag
// - address-to-bus drives address, routes memory to counter
// - data strobe copies stored address into counter
// - end of cycle counts address up one
// - write back 220 ns after end, 60 ns
// - 30 ns transfer complete pulse after write back
// - count load command end sets count flag
// - count load command parallel-loads count counter
// - count memory write follows same 90 ns sequence
// - 30 ns pulse after count write clears flag
// - master read drives full 18-bit address
// - even address low byte, odd high byte
// - byte select from address lsb and address-to-bus
// - auto-echo passes received bits, else memory byte
// - two card receive buses merged into one
// - chosen byte goes to selected line's holding register
// - byte count increments with the address
// - programmed load takes bits 17:16 from control
// - count overflow clears selected line's buffer-active bit
//
// Our own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module lacc_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        address_to_bus,
  input  wire logic        data_strobe,
  input  wire logic        end_cycle,
  input  wire logic [3:0]  xmit_scan,
  input  wire logic [15:0] bus_rd_data,
  input  wire logic [7:0]  card_a_rx_bit,
  input  wire logic [7:0]  card_b_rx_bit,
  output logic      [17:0] bus_addr,
  output logic             bus_addr_oe,
  output logic      [7:0]  tx_data,
  output logic             tx_hold_write,
  output logic      [3:0]  tx_line,
  output logic             transfer_complete_pulse,
  output logic             address_memory_write,
  output logic             count_memory_write,
  output logic      [15:0] buffer_active_clear
);
  // per-line memories
  logic [17:0]               line_current_address [0:15];
  logic [15:0]               line_byte_count      [0:15];

  logic [6:0]                system_control_register;
  logic [17:0]               addr_counter;
  logic [15:0]               count_counter;
  logic                      address_load_cmd;
  logic                      count_load_cmd;
  logic                      addr_cmd_prev;
  logic                      count_cmd_prev;
  logic                      address_write_flag;
  logic                      count_write_flag;
  logic                      overflow_seen;
  lacc_pkg::lacc_seq_t       load_state;
  lacc_pkg::lacc_seq_t       inc_state;
  logic [4:0]                load_timer;
  logic [4:0]                inc_timer;
  logic                      end_cycle_prev;
  logic                      strobe_prev;
  logic                      count_inc_pending;

  logic                      apb_access;
  logic                      apb_done;
  logic                      hit_car;
  logic                      hit_bc;
  logic                      hit_scr;
  logic                      hit_status;
  logic                      mapped;
  logic                      load_blocked;
  logic [3:0]                mem_line;
  logic [3:0]                scr_line;
  logic                      load_trailing;
  logic                      end_rise;
  logic                      byte_high;
  logic [7:0]                memory_byte;
  logic [7:0]                rx_merged;
  logic [7:0]                selected_byte;
  logic [15:0]               next_count;
  logic [31:0]               next_rdata;
  logic [15:0]               pwdata_hold;

  assign scr_line   = system_control_register[lacc_pkg::SCR_LINE_LSB +: 4];
  assign hit_scr    = (paddr == lacc_pkg::OFF_SCR);
  assign hit_car    = (paddr == lacc_pkg::OFF_CAR);
  assign hit_bc     = (paddr == lacc_pkg::OFF_BC);
  assign hit_status = (paddr == lacc_pkg::OFF_STATUS);
  assign mapped     = hit_scr | hit_car | hit_bc | hit_status;
  // a load write waits while any sequence still owns the memories
  assign load_blocked = pwrite & (hit_car | hit_bc)
                        & ((load_state != lacc_pkg::SEQ_IDLE)
                           | (inc_state != lacc_pkg::SEQ_IDLE)
                           | address_load_cmd | count_load_cmd);
  assign apb_access = psel & penable & ~pready;
  assign apb_done   = psel & penable & pready;

  assign mem_line = (address_write_flag | count_write_flag) ? scr_line : xmit_scan;

  assign load_trailing = (addr_cmd_prev & ~address_load_cmd)
                         | (count_cmd_prev & ~count_load_cmd);
  assign end_rise      = end_cycle & ~end_cycle_prev;

  assign byte_high = line_current_address[xmit_scan][0] & address_to_bus;
  assign memory_byte = byte_high ? bus_rd_data[15:8] : bus_rd_data[7:0];
  assign rx_merged = card_a_rx_bit | card_b_rx_bit;
  assign selected_byte = system_control_register[lacc_pkg::SCR_AE_BIT]
                         ? rx_merged : memory_byte;

  // apb handshake: one wait state, longer while a load is refused
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (apb_access && !load_blocked) begin
      pready  <= 1'b1;
      pslverr <= ~mapped;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // read data assembled from live state
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (hit_scr) begin
      next_rdata[6:0] = system_control_register;
    end else if (hit_car) begin
      next_rdata[15:0] = line_current_address[scr_line][15:0];
    end else if (hit_bc) begin
      next_rdata[15:0] = line_byte_count[scr_line];
    end else if (hit_status) begin
      next_rdata[lacc_pkg::ST_ADDR_FLAG]  = address_write_flag;
      next_rdata[lacc_pkg::ST_COUNT_FLAG] = count_write_flag;
      next_rdata[lacc_pkg::ST_LOAD_BUSY]  = (load_state != lacc_pkg::SEQ_IDLE);
      next_rdata[lacc_pkg::ST_INC_BUSY]   = (inc_state != lacc_pkg::SEQ_IDLE);
      next_rdata[lacc_pkg::ST_OVERFLOW]   = overflow_seen;
      next_rdata[lacc_pkg::ST_UPPER_LSB +: 2] = line_current_address[scr_line][17:16];
    end
  end

  // read data registered together with pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (apb_access && !load_blocked && !pwrite) begin
      prdata <= next_rdata;
    end else begin
      prdata <= 32'h0000_0000;
    end
  end

  // control register write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      system_control_register <= lacc_pkg::SCR_RESET;
    end else if (apb_done && pwrite && hit_scr) begin
      system_control_register <= pwdata[6:0];
    end
  end

  // load commands last one cycle, issued on the completing write edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      address_load_cmd <= 1'b0;
      count_load_cmd   <= 1'b0;
      addr_cmd_prev    <= 1'b0;
      count_cmd_prev   <= 1'b0;
    end else begin
      address_load_cmd <= apb_done & pwrite & hit_car;
      count_load_cmd   <= apb_done & pwrite & hit_bc;
      addr_cmd_prev    <= address_load_cmd;
      count_cmd_prev   <= count_load_cmd;
    end
  end

  // write flags: set on trailing edge, cleared by the end pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      address_write_flag <= 1'b0;
      count_write_flag   <= 1'b0;
    end else begin
      if (addr_cmd_prev && !address_load_cmd) begin
        address_write_flag <= 1'b1;
      end else if (load_state == lacc_pkg::SEQ_PULSE && load_timer == 5'd1) begin
        address_write_flag <= 1'b0;
      end
      if (count_cmd_prev && !count_load_cmd) begin
        count_write_flag <= 1'b1;
      end else if (load_state == lacc_pkg::SEQ_PULSE && load_timer == 5'd1) begin
        count_write_flag <= 1'b0;
      end
    end
  end

  // load one-shot chain shared by address and count
  // counts rounded up in package
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_state <= lacc_pkg::SEQ_IDLE;
      load_timer <= 5'd0;
    end else begin
      case (load_state)
        lacc_pkg::SEQ_IDLE: begin
          if (load_trailing) begin
            load_state <= lacc_pkg::SEQ_DELAY;
            load_timer <= lacc_pkg::LOAD_DELAY_CYC;
          end
        end
        lacc_pkg::SEQ_DELAY: begin
          if (load_timer == 5'd1) begin
            load_state <= lacc_pkg::SEQ_WRITE;
            load_timer <= lacc_pkg::WRITE_WIDTH_CYC;
          end else begin
            load_timer <= load_timer - 5'd1;
          end
        end
        lacc_pkg::SEQ_WRITE: begin
          if (load_timer == 5'd1) begin
            load_state <= lacc_pkg::SEQ_PULSE;
            load_timer <= lacc_pkg::DONE_PULSE_CYC;
          end else begin
            load_timer <= load_timer - 5'd1;
          end
        end
        lacc_pkg::SEQ_PULSE: begin
          if (load_timer == 5'd1) begin
            load_state <= lacc_pkg::SEQ_IDLE;
            load_timer <= 5'd0;
          end else begin
            load_timer <= load_timer - 5'd1;
          end
        end
        default: begin
          load_state <= lacc_pkg::SEQ_IDLE;
          load_timer <= 5'd0;
        end
      endcase
    end
  end

  // increment one-shot chain, started by end of cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inc_state <= lacc_pkg::SEQ_IDLE;
      inc_timer <= 5'd0;
    end else begin
      case (inc_state)
        lacc_pkg::SEQ_IDLE: begin
          if (end_rise) begin
            inc_state <= lacc_pkg::SEQ_DELAY;
            inc_timer <= lacc_pkg::INC_DELAY_CYC;
          end
        end
        lacc_pkg::SEQ_DELAY: begin
          if (inc_timer == 5'd1) begin
            inc_state <= lacc_pkg::SEQ_WRITE;
            inc_timer <= lacc_pkg::WRITE_WIDTH_CYC;
          end else begin
            inc_timer <= inc_timer - 5'd1;
          end
        end
        lacc_pkg::SEQ_WRITE: begin
          if (inc_timer == 5'd1) begin
            inc_state <= lacc_pkg::SEQ_PULSE;
            inc_timer <= lacc_pkg::DONE_PULSE_CYC;
          end else begin
            inc_timer <= inc_timer - 5'd1;
          end
        end
        lacc_pkg::SEQ_PULSE: begin
          if (inc_timer == 5'd1) begin
            inc_state <= lacc_pkg::SEQ_IDLE;
            inc_timer <= 5'd0;
          end else begin
            inc_timer <= inc_timer - 5'd1;
          end
        end
        default: begin
          inc_state <= lacc_pkg::SEQ_IDLE;
          inc_timer <= 5'd0;
        end
      endcase
    end
  end

  // edge memory for the sequencer strobes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      end_cycle_prev <= 1'b0;
      strobe_prev    <= 1'b0;
    end else begin
      end_cycle_prev <= end_cycle;
      strobe_prev    <= data_strobe;
    end
  end

  // address counter: programmed load, copy from memory, count up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_counter <= 18'h0_0000;
    end else if (address_load_cmd) begin
      addr_counter <= {system_control_register[lacc_pkg::SCR_EXT_LSB +: 2],
                       pwdata_hold};
    end else if (address_to_bus && data_strobe) begin
      addr_counter <= line_current_address[xmit_scan];
    end else if (end_rise) begin
      addr_counter <= addr_counter + 18'h0_0001;
    end
  end

  // bus data captured on the write edge, the same edge that registers the command
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwdata_hold <= 16'h0000;
    end else if (apb_done && pwrite && (hit_car || hit_bc)) begin
      pwdata_hold <= pwdata[15:0];
    end
  end

  // byte count counter follows the address counter
  assign next_count = count_counter + 16'h0001;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_counter     <= 16'h0000;
      count_inc_pending <= 1'b0;
    end else if (count_load_cmd) begin
      count_counter     <= pwdata_hold;
      count_inc_pending <= 1'b0;
    end else if (address_to_bus && data_strobe) begin
      count_counter     <= line_byte_count[xmit_scan];
      count_inc_pending <= 1'b0;
    end else if (end_rise) begin
      count_counter     <= next_count;
      count_inc_pending <= 1'b1;
    end else if (inc_state == lacc_pkg::SEQ_IDLE) begin
      count_inc_pending <= 1'b0;
    end
  end

  // per-line memory writes from either chain
  always_ff @(posedge pclk) begin
    if (load_state == lacc_pkg::SEQ_WRITE && address_write_flag) begin
      line_current_address[mem_line] <= addr_counter;
    end else if (inc_state == lacc_pkg::SEQ_WRITE) begin
      line_current_address[mem_line] <= addr_counter;
    end
    if (load_state == lacc_pkg::SEQ_WRITE && count_write_flag) begin
      line_byte_count[mem_line] <= count_counter;
    end else if (inc_state == lacc_pkg::SEQ_WRITE) begin
      line_byte_count[mem_line] <= count_counter;
    end
  end

  // visible strobes and completion pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      address_memory_write    <= 1'b0;
      count_memory_write      <= 1'b0;
      transfer_complete_pulse <= 1'b0;
    end else begin
      address_memory_write <= (lacc_pkg::SEQ_WRITE == load_state && address_write_flag)
                              | (inc_state == lacc_pkg::SEQ_WRITE);
      count_memory_write   <= (lacc_pkg::SEQ_WRITE == load_state && count_write_flag)
                              | (inc_state == lacc_pkg::SEQ_WRITE);
      transfer_complete_pulse <= (inc_state == lacc_pkg::SEQ_PULSE);
    end
  end

  // overflow after an increment clears that line's buffer-active bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buffer_active_clear <= 16'h0000;
      overflow_seen       <= 1'b0;
    end else begin
      buffer_active_clear <= 16'h0000;
      // wrap to zero clears one bit
      if (count_inc_pending && inc_state == lacc_pkg::SEQ_WRITE
          && inc_timer == lacc_pkg::WRITE_WIDTH_CYC && count_counter == 16'h0000) begin
        buffer_active_clear[mem_line] <= 1'b1;
        overflow_seen                 <= 1'b1;
      end else if (apb_done && !pwrite && hit_status) begin
        overflow_seen <= 1'b0;   // read clears; a new overflow above wins
      end
    end
  end

  // master address drive and transmit byte delivery
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_addr      <= 18'h0_0000;
      bus_addr_oe   <= 1'b0;
      tx_data       <= 8'h00;
      tx_hold_write <= 1'b0;
      tx_line       <= 4'h0;
    end else begin
      bus_addr      <= address_to_bus ? line_current_address[xmit_scan] : 18'h0_0000;
      bus_addr_oe   <= address_to_bus;
      tx_hold_write <= 1'b0;
      if (data_strobe && !strobe_prev) begin
        tx_data       <= selected_byte;
        tx_hold_write <= 1'b1;
        tx_line       <= xmit_scan;
      end
    end
  end
endmodule

// >>> tb.sv
// self-checking bench for the line address and byte-count control block
// assumes apb master and sequencer driven here, memory from lacc_mem_model
`timescale 1ns/1ps
module tb;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rdata;
  logic        pready, pslverr, rerr;
  logic        address_to_bus = 1'b0;
  logic        data_strobe = 1'b0;
  logic        end_cycle = 1'b0;
  logic [3:0]  xmit_scan = 4'h3;
  logic [15:0] bus_rd_data;
  logic [7:0]  card_a_rx_bit = 8'h00;
  logic [7:0]  card_b_rx_bit = 8'h00;
  logic [17:0] bus_addr;
  logic [7:0]  tx_data;
  logic [3:0]  tx_line;
  logic [15:0] buffer_active_clear;
  logic [15:0] bac = 16'h0;
  logic        bus_addr_oe, tx_hold_write, transfer_complete_pulse;
  logic        address_memory_write, count_memory_write;
  int          fails, total_checks, cycles, amw_n, cmw_n;

  lacc_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .address_to_bus, .data_strobe, .end_cycle, .xmit_scan,
    .bus_rd_data, .card_a_rx_bit, .card_b_rx_bit, .bus_addr, .bus_addr_oe, .tx_data,
    .tx_hold_write, .tx_line, .transfer_complete_pulse, .address_memory_write,
    .count_memory_write, .buffer_active_clear);
  lacc_mem_model i_mem (.pclk, .bus_addr, .bus_addr_oe, .bus_rd_data);

  always #5 pclk = ~pclk;

  // strobe widths, overflow clears and the hang guard
  always @(posedge pclk) begin
    cycles++;
    // outputs are unknown until the first reset edge has been taken
    if (presetn) begin
      amw_n += address_memory_write;
      cmw_n += count_memory_write;
      bac |= buffer_active_clear;
    end
    if (cycles == 20000) begin
      fails++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer; waits on pready with a bound
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    rdata = prdata;
    rerr = pslverr;
    chk(32'(pready), 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // first status read must show the flag, then poll until idle
  task automatic settle(input int bitn);
    int n;
    n = 0;
    apb(1'b0, lacc_pkg::OFF_STATUS, 32'h0);
    chk(32'(rdata[bitn]), 32'h1);
    while (rdata[3:0] !== 4'h0 && n < 50) begin
      apb(1'b0, lacc_pkg::OFF_STATUS, 32'h0);
      n++;
    end
    chk(32'(rdata[3:0]), 32'h0);
  endtask

  // one sequencer increment cycle on line 3
  task automatic inc(input logic [17:0] ea, input logic [7:0] eb);
    int n;
    n = 0;
    @(posedge pclk);
    address_to_bus <= 1'b1;
    repeat (2) @(posedge pclk);
    data_strobe <= 1'b1;
    #1 chk(32'(bus_addr), 32'(ea));
    repeat (2) @(posedge pclk);
    // strobe released in the cycle end_cycle rises: a held copy would mask the count-up
    end_cycle <= 1'b1;
    data_strobe <= 1'b0;
    #1 chk(32'(tx_data), 32'(eb));
    chk(32'(tx_line), 32'h3);
    repeat (3) @(posedge pclk);
    address_to_bus <= 1'b0;
    end_cycle <= 1'b0;
    while (transfer_complete_pulse !== 1'b1 && n < 60) begin
      @(posedge pclk);
      n++;
    end
    chk(32'(transfer_complete_pulse), 32'h1);
    repeat (4) @(posedge pclk);
  endtask

  task automatic t_regs();
    apb(1'b0, lacc_pkg::OFF_SCR, 32'h0);
    chk(rdata, 32'(lacc_pkg::SCR_RESET));
    apb(1'b0, 12'h010, 32'h0);
    chk(32'(rerr), 32'h1);
    chk(rdata, 32'h0);
    apb(1'b1, lacc_pkg::OFF_SCR, 32'h23);
    apb(1'b0, lacc_pkg::OFF_SCR, 32'h0);
    chk(rdata, 32'h23);
  endtask

  task automatic t_load();
    apb(1'b1, lacc_pkg::OFF_CAR, 32'h1235);
    settle(lacc_pkg::ST_ADDR_FLAG);
    chk(32'(amw_n), 32'h6);
    apb(1'b1, lacc_pkg::OFF_BC, 32'hfffe);
    settle(lacc_pkg::ST_COUNT_FLAG);
    chk(32'(cmw_n), 32'h6);
    apb(1'b0, lacc_pkg::OFF_CAR, 32'h0);
    chk(rdata, 32'h1235);
    apb(1'b0, lacc_pkg::OFF_STATUS, 32'h0);
    chk(32'(rdata[7:6]), 32'h2);
    apb(1'b0, lacc_pkg::OFF_BC, 32'h0);
    chk(rdata, 32'hfffe);
  endtask

  task automatic t_inc();
    inc(18'h21235, 8'hca);
    apb(1'b0, lacc_pkg::OFF_CAR, 32'h0);
    chk(rdata, 32'h1236);
    apb(1'b0, lacc_pkg::OFF_BC, 32'h0);
    chk(rdata, 32'hffff);
    chk(32'(bac), 32'h0);
    inc(18'h21236, 8'h36);
    chk(32'(bac), 32'h0008);
    apb(1'b0, lacc_pkg::OFF_BC, 32'h0);
    chk(rdata, 32'h0);
    apb(1'b1, lacc_pkg::OFF_SCR, 32'h63);
    card_a_rx_bit <= 8'h41;
    card_b_rx_bit <= 8'h02;
    inc(18'h21237, 8'h43);
    apb(1'b0, lacc_pkg::OFF_CAR, 32'h0);
    chk(rdata, 32'h1238);
  endtask

  // reset, then the scenarios in order
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_load();
    t_inc();
    wrap_up();
  end
endmodule
